// [logic/mnre_alu.sv]
// arithmetic for the execution block: unsigned 8x8 product and negation
// assumes operands are stable through the phase that samples the result
`timescale 1ns/1ns
module mnre_alu (
  // operands
  input  wire logic [7:0]         i_work,
  input  wire logic [7:0]         i_opnd,
  // results
  output mnre_pkg::mnre_alu_s     o_res
);

  logic [7:0] inv_w;
  logic [8:0] sum_full;
  logic [4:0] sum_low;

  assign inv_w    = ~i_work;
  assign sum_full = {1'b0, inv_w} + 9'h001;
  assign sum_low  = {1'b0, inv_w[3:0]} + 5'h01;

  assign o_res.prod     = 16'(i_work) * 16'(i_opnd);
  assign o_res.neg      = sum_full[7:0];
  assign o_res.flags.c  = sum_full[8];
  assign o_res.flags.dc = sum_low[4];
  // adding +1 to a positive value can only overflow into the sign bit
  assign o_res.flags.ov = ~inv_w[7] & sum_full[7];
  assign o_res.flags.z  = (sum_full[7:0] == 8'h00);

endmodule // mnre_alu

// [logic/mnre_cfg.svh]
// constants of the multiply / negate / return execution block
// assumes inclusion by bare name from logic/
`ifndef MNRE_CFG_SVH
`define MNRE_CFG_SVH

// opcode patterns
`define MNRE_OP_MUL_HI   8'h34
`define MNRE_OP_NEG_HI   7'h16
`define MNRE_OP_RET      16'h0005
`define MNRE_OP_NOP      16'h0000

// field positions
`define MNRE_GID_BIT     4
`define MNRE_SEL_BIT     8
`define MNRE_RUN_BIT     0

// register byte offsets
`define MNRE_OFF_WORK    8'h00
`define MNRE_OFF_PROD    8'h04
`define MNRE_OFF_FLAGS   8'h08
`define MNRE_OFF_STATUS  8'h0c
`define MNRE_OFF_PC      8'h10
`define MNRE_OFF_PCLAT   8'h14
`define MNRE_OFF_CTRL    8'h18
`define MNRE_OFF_STATE   8'h1c

// reset values
`define MNRE_RST_BYTE    8'h00
`define MNRE_RST_STATUS  8'h10
`define MNRE_RST_CTRL    8'h01
`define MNRE_RST_PC      16'h0000

`endif

// [logic/mnre_exec.sv]
// execution of multiply_by_file, negate_working, no_operation and
// return_from_interrupt over four phases per instruction cycle, with an APB slave
// assumes instructions, file data and stack top are synchronous to i_clk_sys
`timescale 1ns/1ns
`include "mnre_cfg.svh"

// How it works
// - upper byte 0x34 decodes multiply_by_file
// - working_register times file byte into product pair
// - multiply leaves working and file registers
// - multiply touches no status flag
// - upper bits 0010110 decode negate_working
// - negation is invert then add one
// - select 0 writes working and file
// - select 1 writes file only
// - negate updates overflow, carry, digit carry, zero
// - code 0x0005 decodes return_from_interrupt
// - return pops stack top into program counter
// - return clears global_interrupt_disable, status bit 4
module mnre_exec (
  // clock, reset, enable
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst,
  input  wire logic                      i_ce,
  // apb slave
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [7:0]                i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output logic      [31:0]               o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  // instruction issue
  input  wire logic                      i_instr_valid,
  input  wire logic [15:0]               i_instr,
  output logic                           o_instr_ready,
  // file register port
  output mnre_pkg::mnre_file_req_s       o_file,
  input  wire logic [7:0]                i_file_rdata,
  // hardware stack
  output logic                           o_stack_pop,
  input  wire logic [15:0]               i_stack_top,
  // core state
  output logic      [15:0]               o_pc,
  output mnre_pkg::mnre_phase_e          o_phase,
  output logic                           o_glbl_int_disable
);

  mnre_pkg::mnre_phase_e    phase;
  mnre_pkg::mnre_op_e       op;
  mnre_pkg::mnre_op_e       dec_op;
  mnre_pkg::mnre_flags_s    flags;
  mnre_pkg::mnre_file_req_s file_q;
  mnre_pkg::mnre_alu_s      alu;
  logic                     second;
  logic                     sel_s;
  logic [7:0]               opnd;
  logic [7:0]               work_reg;
  logic [7:0]               prod_h;
  logic [7:0]               prod_l;
  logic [7:0]               plat;
  logic [7:0]               ctrl;
  logic [7:0]               cpu_status;
  logic [15:0]              pc;
  logic                     pop_q;
  logic [31:0]              prdata_q;

  // decode
  logic is_q1, is_q2, is_q3, is_q4, run, take;
  logic op_mul, op_neg, op_ret, op_nop;
  logic adv_pc, neg_to_w;

  assign is_q1  = (phase == mnre_pkg::PH_Q1);
  assign is_q2  = (phase == mnre_pkg::PH_Q2);
  assign is_q3  = (phase == mnre_pkg::PH_Q3);
  assign is_q4  = (phase == mnre_pkg::PH_Q4);
  assign run    = ctrl[`MNRE_RUN_BIT];
  assign take   = is_q1 & ~second & run & i_instr_valid;
  assign op_mul = (op == mnre_pkg::OP_MUL);
  assign op_neg = (op == mnre_pkg::OP_NEG);
  assign op_ret = (op == mnre_pkg::OP_RET);
  assign op_nop = (op == mnre_pkg::OP_NOP);

  assign dec_op = (i_instr[15:8] == `MNRE_OP_MUL_HI) ? mnre_pkg::OP_MUL :
                  (i_instr[15:9] == `MNRE_OP_NEG_HI) ? mnre_pkg::OP_NEG :
                  (i_instr == `MNRE_OP_RET)          ? mnre_pkg::OP_RET :
                  (i_instr == `MNRE_OP_NOP)          ? mnre_pkg::OP_NOP :
                  mnre_pkg::OP_OTHER;

  // every decoded word but return moves on by one word
  assign adv_pc   = is_q4 & (op != mnre_pkg::OP_IDLE) & ~op_ret;
  assign neg_to_w = is_q4 & op_neg & ~sel_s;

  // apb decode
  logic apb_wr, apb_setup;
  logic hit_w, hit_prod, hit_flags, hit_sta, hit_pc, hit_plat, hit_ctrl, hit_state, hit;
  logic [31:0] rd_mux;

  assign apb_wr    = i_psel & i_penable & i_pwrite & i_ce;
  assign apb_setup = i_psel & ~i_penable;
  assign hit_w     = (i_paddr == `MNRE_OFF_WORK);
  assign hit_prod  = (i_paddr == `MNRE_OFF_PROD);
  assign hit_flags = (i_paddr == `MNRE_OFF_FLAGS);
  assign hit_sta   = (i_paddr == `MNRE_OFF_STATUS);
  assign hit_pc    = (i_paddr == `MNRE_OFF_PC);
  assign hit_plat  = (i_paddr == `MNRE_OFF_PCLAT);
  assign hit_ctrl  = (i_paddr == `MNRE_OFF_CTRL);
  assign hit_state = (i_paddr == `MNRE_OFF_STATE);
  assign hit       = hit_w | hit_prod | hit_flags | hit_sta | hit_pc | hit_plat
                   | hit_ctrl | hit_state;

  assign rd_mux = hit_w     ? {24'h000000, work_reg} :
                  hit_prod  ? {16'h0000, prod_h, prod_l} :
                  hit_flags ? {28'h0000000, flags} :
                  hit_sta   ? {24'h000000, cpu_status} :
                  hit_pc    ? {16'h0000, pc} :
                  hit_plat  ? {24'h000000, plat} :
                  hit_ctrl  ? {24'h000000, ctrl} :
                  hit_state ? {28'h0000000, second, 1'b0, phase} :
                  32'h00000000;

  // a frozen block cannot take a write, so the bus waits with it
  assign o_pready  = i_ce;
  assign o_pslverr = i_psel & i_penable & ~hit;
  assign o_prdata  = prdata_q;

  assign o_instr_ready      = is_q1 & ~second & run & i_ce;
  assign o_file             = file_q;
  assign o_stack_pop        = pop_q;
  assign o_pc               = pc;
  assign o_phase            = phase;
  assign o_glbl_int_disable = cpu_status[`MNRE_GID_BIT];

  mnre_alu u_alu (
    .i_work (work_reg),
    .i_opnd (opnd),
    .o_res  (alu)
  );

  // phase sequencer and instruction latch
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      phase  <= mnre_pkg::PH_Q1;
      op     <= mnre_pkg::OP_IDLE;
      sel_s  <= 1'b0;
      second <= 1'b0;
    end else if (i_ce) begin
      phase <= mnre_pkg::mnre_phase_e'(phase + 2'd1);
      if (is_q1) begin
        op    <= take ? dec_op : mnre_pkg::OP_IDLE;
        sel_s <= i_instr[`MNRE_SEL_BIT];
      end
      if (is_q4) begin
        second <= op_ret;
      end
    end
  end

  // operand fetch and file port
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      opnd   <= `MNRE_RST_BYTE;
      file_q <= '0;
    end else if (i_ce) begin
      if (take) begin
        file_q.addr <= i_instr[7:0];
      end
      if (is_q2) begin
        opnd <= i_file_rdata;
      end
      // multiply never raises the write strobe
      file_q.we <= is_q3 & op_neg;
      if (is_q3) begin
        file_q.wdata <= alu.neg;
      end
    end
  end

  // working register, products, flags
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      work_reg <= `MNRE_RST_BYTE;
      prod_h   <= `MNRE_RST_BYTE;
      prod_l   <= `MNRE_RST_BYTE;
      flags    <= '0;
    end else if (i_ce) begin
      // hardware write wins over a bus write in the same cycle
      if (neg_to_w) begin
        work_reg <= alu.neg;
      end else if (apb_wr && hit_w) begin
        work_reg <= i_pwdata[7:0];
      end
      if (is_q4 && op_mul) begin
        prod_h <= alu.prod[15:8];
        prod_l <= alu.prod[7:0];
      end
      if (is_q4 && op_neg) begin
        flags <= alu.flags;
      end else if (apb_wr && hit_flags) begin
        flags <= i_pwdata[3:0];
      end
    end
  end

  // status, program counter, stack pop
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cpu_status <= `MNRE_RST_STATUS;
      pc         <= `MNRE_RST_PC;
      pop_q      <= 1'b0;
    end else if (i_ce) begin
      if (apb_wr && hit_sta) begin
        cpu_status <= i_pwdata[7:0];
      end
      // later assignment lets a return clear beat a software set
      if (is_q3 && op_ret) begin
        cpu_status[`MNRE_GID_BIT] <= 1'b0;
      end
      pop_q <= is_q3 & op_ret;
      if (is_q4 && op_ret) begin
        pc <= i_stack_top;
      end else if (adv_pc) begin
        pc <= pc + 16'h0001;
      end
    end
  end

  // software registers and read data
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      plat     <= `MNRE_RST_BYTE;
      ctrl     <= `MNRE_RST_CTRL;
      prdata_q <= 32'h00000000;
    end else if (i_ce) begin
      if (apb_wr && hit_plat) begin
        plat <= i_pwdata[7:0];
      end
      if (apb_wr && hit_ctrl) begin
        ctrl <= i_pwdata[7:0];
      end
      if (apb_setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // checks
  // antecedents carry i_ce so a frozen block never trips a check
  // expectations use operands as they stood, not the unit's outputs
  a_mul_product: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && is_q4 && op_mul) |=> ({prod_h, prod_l} == $past(work_reg) * $past(opnd)))
    else $error("product pair does not hold the multiply result");

  a_mul_keeps_regs: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && is_q3 && op_mul) |=> (!file_q.we ##1 $stable(work_reg)))
    else $error("multiply disturbed working or file register");

  a_mul_no_flags: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && is_q4 && op_mul && !(apb_wr && hit_flags)) |=> $stable(flags))
    else $error("multiply changed a status flag");

  a_neg_file_wr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && is_q3 && op_neg) |=> (file_q.we && file_q.wdata == 8'(~$past(work_reg) + 8'h01)))
    else $error("negate file write missing or wrong");

  a_neg_to_work: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && is_q4 && op_neg && !sel_s) |=> (work_reg == 8'(~$past(work_reg) + 8'h01)))
    else $error("negate with select 0 did not update working register");

  a_neg_file_only: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && is_q4 && op_neg && sel_s && !(apb_wr && hit_w)) |=> $stable(work_reg))
    else $error("negate with select 1 changed working register");

  a_neg_zero_flag: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && is_q4 && op_neg) |=> (flags.z == ($past(work_reg) == 8'h00)))
    else $error("negate zero flag wrong");

  a_neg_carry_ov: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && is_q4 && op_neg) |=>
      (flags.c == ($past(work_reg) == 8'h00) && flags.ov == ($past(work_reg) == 8'h80)))
    else $error("negate carry or overflow flag wrong");

  a_neg_digit_carry: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && is_q4 && op_neg) |=> (flags.dc == ($past(work_reg[3:0]) == 4'h0)))
    else $error("negate digit carry flag wrong");

  a_ret_gid_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && is_q3 && op_ret) |=> (!o_glbl_int_disable && o_stack_pop))
    else $error("return did not clear interrupt disable or pop");

  a_ret_pc_load: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && is_q4 && op_ret) |=> (pc == $past(i_stack_top) && second && !o_instr_ready))
    else $error("return did not load stack top or skip one cycle");

  a_ret_latch_kept: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && op_ret && !(apb_wr && hit_plat)) |=> $stable(plat))
    else $error("return changed pc_high_latch");

  a_nop_advance: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_ce && is_q4 && op_nop) |=> (pc == $past(pc) + 16'h0001 && $stable(work_reg)))
    else $error("no_operation did more than advance the program counter");

endmodule // mnre_exec

// [logic/mnre_pkg.sv]
// types shared by the execution block and its arithmetic unit
// assumes nothing beyond a SystemVerilog compiler
package mnre_pkg;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} mnre_phase_e;

  typedef enum logic [2:0] {OP_IDLE, OP_MUL, OP_NEG, OP_NOP, OP_RET, OP_OTHER} mnre_op_e;

  typedef struct packed {
    logic ov;
    logic c;
    logic dc;
    logic z;
  } mnre_flags_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
  } mnre_file_req_s;

  typedef struct packed {
    logic [15:0] prod;
    logic [7:0]  neg;
    mnre_flags_s flags;
  } mnre_alu_s;

endpackage

// [test/mnre_exec_test.sv]
// self-checking bench for the multiply / negate / return execution block
// assumes the register map and phase timing of the execution block
`timescale 1ns/1ns
`define MNRE_CHECK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end \
  end

module mnre_exec_test;
  logic                     i_clk_sys, i_rst, i_ce;
  logic                     i_psel, i_penable, i_pwrite;
  logic [7:0]               i_paddr;
  logic [31:0]              i_pwdata, o_prdata;
  logic                     o_pready, o_pslverr;
  logic                     i_instr_valid, o_instr_ready;
  logic [15:0]              i_instr, i_stack_top, o_pc;
  mnre_pkg::mnre_file_req_s o_file, fq;
  logic [7:0]               i_file_rdata, w, neg;
  logic                     o_stack_pop, o_glbl_int_disable;
  mnre_pkg::mnre_phase_e    o_phase, ph;
  int                       errors, num_checks, cyc;
  logic [15:0]              epc;
  logic [31:0]              rdv;
  logic                     err, pop, g3, g4, s;

  mnre_exec u_dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .o_instr_ready(o_instr_ready),
    .o_file(o_file), .i_file_rdata(i_file_rdata),
    .o_stack_pop(o_stack_pop), .i_stack_top(i_stack_top),
    .o_pc(o_pc), .o_phase(o_phase), .o_glbl_int_disable(o_glbl_int_disable)
  );

  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      report_and_stop();
    end
  end

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk_sys);
    end while (o_pready !== 1'b1);
    rdv = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `MNRE_CHECK(nm, e, rdv)
  endtask

  // offer held until taken in Q1; Q3 and Q4 outputs seen at their ending edges
  task automatic issue(input logic [15:0] ins, input logic [7:0] fd);
    @(posedge i_clk_sys);
    i_instr <= ins;
    i_file_rdata <= fd;
    i_instr_valid <= 1'b1;
    do begin
      @(posedge i_clk_sys);
    end while (!(o_instr_ready === 1'b1 && o_phase === mnre_pkg::PH_Q1));
    i_instr_valid <= 1'b0;
    @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    g3 = o_glbl_int_disable;
    @(posedge i_clk_sys);
    fq = o_file;
    pop = o_stack_pop;
    g4 = o_glbl_int_disable;
    epc = epc + 16'h0001;
  endtask

  initial begin
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0000_0000;
    i_instr_valid = 1'b0;
    i_instr = 16'h0000;
    i_file_rdata = 8'h00;
    i_stack_top = 16'h0000;
    epc = 16'h0000;
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rd_chk("cpu_status", 8'h0c, 32'h0000_0010);
    rd_chk("ctrl", 8'h18, 32'h0000_0001);
    apb(1'b0, 8'h20, 32'h0000_0000);
    `MNRE_CHECK("unmapped err", 1'b1, err)
    `MNRE_CHECK("unmapped data", 32'h0000_0000, rdv)
    $display("test reset_map done");
    // a frozen block holds its phase and stalls the bus
    i_ce <= 1'b0;
    @(posedge i_clk_sys);
    ph = o_phase;
    repeat (3) @(posedge i_clk_sys);
    `MNRE_CHECK("frozen phase", ph, o_phase)
    `MNRE_CHECK("frozen ready", 1'b0, o_pready)
    i_ce <= 1'b1;
    $display("test freeze done");

    wr(8'h00, 32'h0000_00c4);
    wr(8'h08, 32'h0000_0005);
    issue(16'h34b5, 8'hb5);
    `MNRE_CHECK("mul addr", 8'hb5, fq.addr)
    `MNRE_CHECK("mul we", 1'b0, fq.we)
    rd_chk("product", 8'h04, 32'h0000_8a94);
    rd_chk("work reg", 8'h00, 32'h0000_00c4);
    rd_chk("flags", 8'h08, 32'h0000_0005);
    `MNRE_CHECK("pc", epc, o_pc)
    wr(8'h00, 32'h0000_0000);
    wr(8'h08, 32'h0000_0000);
    issue(16'h3400, 8'h55);
    rd_chk("product zero", 8'h04, 32'h0000_0000);
    rd_chk("flags zero", 8'h08, 32'h0000_0000);
    $display("test multiply done");

    for (int i = 0; i < 8; i++) begin
      w = (i[2:1] == 2'd0) ? 8'h3a : (i[2:1] == 2'd1) ? 8'h00 : (i[2:1] == 2'd2) ? 8'h80 : 8'h01;
      s = i[0];
      neg = ~w + 8'h01;
      wr(8'h00, {24'h000000, w});
      issue({7'h16, s, 8'h40 + 8'(i)}, 8'hab);
      `MNRE_CHECK("neg we", 1'b1, fq.we)
      `MNRE_CHECK("neg addr", 8'h40 + 8'(i), fq.addr)
      `MNRE_CHECK("neg data", neg, fq.wdata)
      rd_chk("neg work reg", 8'h00, {24'h000000, s ? w : neg});
      rd_chk("neg flags", 8'h08, {28'h0, w == 8'h80, w == 8'h00, w[3:0] == 4'h0,
             neg == 8'h00});
    end
    `MNRE_CHECK("pc", epc, o_pc)
    $display("test negate done");

    wr(8'h00, 32'h0000_0077);
    wr(8'h08, 32'h0000_000a);
    issue(16'h0000, 8'h99);
    `MNRE_CHECK("nop we", 1'b0, fq.we)
    // the counter moves at the edge that ends the issue task
    @(posedge i_clk_sys);
    `MNRE_CHECK("nop pc", epc, o_pc)
    rd_chk("nop work reg", 8'h00, 32'h0000_0077);
    rd_chk("nop flags", 8'h08, 32'h0000_000a);
    rd_chk("nop product", 8'h04, 32'h0000_0000);
    $display("test nop done");

    wr(8'h14, 32'h0000_0012);
    i_stack_top <= 16'h1234;
    issue(16'h0005, 8'h00);
    `MNRE_CHECK("gid in q3", 1'b1, g3)
    `MNRE_CHECK("gid in q4", 1'b0, g4)
    `MNRE_CHECK("pop", 1'b1, pop)
    @(posedge i_clk_sys);
    `MNRE_CHECK("ret bubble", 1'b0, o_instr_ready)
    `MNRE_CHECK("ret pc", 16'h1234, o_pc)
    rd_chk("cpu_status", 8'h0c, 32'h0000_0000);
    rd_chk("pc_high_latch", 8'h14, 32'h0000_0012);
    $display("test return done");
    report_and_stop();
  end
endmodule // mnre_exec_test
